// File: src/lsgpc_pkg.sv
// Purpose: constants and state type for the lamp, aux and glass controller
// Assumes: 8-bit register port, 4-bit register address
// Notes:   offsets are byte addresses on the plain register port
package lsgpc_pkg;

    // ==========================================================
    // widths
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned LAMP_N = 3;
    localparam int unsigned CODE_W = 6;

    // ==========================================================
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_SYS_CTRL    = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_HS_OUT_CTRL = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_HS_FAULTS   = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_GLASS_STAT  = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_GLASS_CODE  = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS   = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK    = 4'h9;

    // ==========================================================
    // field positions
    localparam int unsigned POS_POWER_STAGES_ENABLE      = 7;  // sys ctrl
    localparam int unsigned POS_HOT_SDDIS = 3;  // sys ctrl
    localparam int unsigned POS_LAMP_ON   = 0;  // hs out, 3 bits
    localparam int unsigned POS_LAMP_PWM  = 3;  // hs out, 3 bits
    localparam int unsigned POS_AUX_ON    = 7;  // hs out
    localparam int unsigned POS_LAMP_OC   = 0;  // hs faults, 3 bits
    localparam int unsigned POS_AUX_OC    = 4;  // hs faults
    localparam int unsigned POS_GL_REG    = 7;  // glass stat
    localparam int unsigned POS_GL_TEST   = 6;  // glass stat
    localparam int unsigned POS_GL_SUP    = 5;  // glass stat
    localparam int unsigned POS_GL_SHORT  = 1;  // glass stat
    localparam int unsigned POS_GL_OPEN   = 0;  // glass stat
    localparam int unsigned POS_HOT_FLAG  = 0;  // irq flags / mask

    // ==========================================================
    // synchroniser lanes of the pin inputs
    localparam int unsigned SY_PWM    = 0;
    localparam int unsigned SY_HOT    = 1;
    localparam int unsigned SY_HOT2   = 2;
    localparam int unsigned SY_LOC    = 3;  // 3 lanes
    localparam int unsigned SY_AUXOC  = 6;
    localparam int unsigned SY_GSHORT = 7;
    localparam int unsigned SY_GOPEN  = 8;
    localparam int unsigned SYNC_W    = 9;

    // ==========================================================
    // reset values
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    localparam logic [CODE_W-1:0] RST_CODE = 6'h00;

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic              pwm_prev;
        logic              power_stages_enable;
        logic              hot_sd_dis;
        logic              hot_mask;
        logic              hot_flag;
        logic [LAMP_N-1:0] lamp_on;
        logic [LAMP_N-1:0] lamp_pwm;
        logic              aux_on;
        logic [LAMP_N-1:0] lamp_oc;
        logic [LAMP_N-1:0] lamp_cut;
        logic              aux_oc;
        logic              gl_reg;
        logic              gl_sup;
        logic              gl_test;
        logic              gl_short;
        logic              gl_open;
        logic [CODE_W-1:0] gl_code;
        logic [DATA_W-1:0] rd_data;
        logic [LAMP_N-1:0] lamp_drv;
        logic              aux_drv;
        logic              hb_high_off;
        logic              hb_low_off;
        logic              h0_off;
        logic              stages_en;
        logic              gl_reg_drv;
        logic              gl_sup_drv;
        logic              gl_test_src;
        logic [CODE_W-1:0] gl_code_out;
        logic              irq;
    } lsgpc_state_t;

endpackage

// File: src/lsgpc_top.sv
// Purpose: protection and control of three lamp switches, the switchable
//          aux 5 V output and the glass driver
// Assumes: pin inputs are asynchronous; one 250 MHz clock SYS_CLK
// Notes:   outputs lag the registers by one cycle and the pins by three
//
// Notes on behaviour
// RULE1: first hot threshold sets hot warning flag
// RULE2: hot interrupt only while its mask set
// RULE3: hot flag turns high sides off, unless disabled
// RULE4: hot flag write-one clears, not while hot
// RULE5: second threshold kills all stages if disabled
// RULE6: lamp over-current switches off, sets flag
// RULE7: pwm rising edge re-enables cut lamp driver; plain on mode (on bit without follow) waits for a written one instead
// RULE8: software judges short by flag duration
// RULE9: aux output needs stages enable and on
// RULE10: supply flags never touch aux output
// RULE11: aux over-current limits, sets flag only
// RULE12: lamp on bit holds switch on
// RULE13: pulse-follow bit makes lamp track pwm
// RULE14: lamp flag write-one clears, re-enables driver
// RULE15: aux flag write-one clears it
// RULE16: open-load test sets flag on high pin
// RULE17: open-load test disables glass drive
// RULE18: glass short sets flag, disables glass
// RULE19: glass short flag write-one clears, re-enables
// RULE20: glass open flag write-one clears, disables glass
// RULE21: six-bit glass voltage code, upper bits zero
// RULE22: regulator and supply enables, reset cleared
// RULE23: stages enable gates all power outputs; here the glass drives, test source and H0_OFF ignore it
// RULE24: shutdown-disable bit one blocks auto shutdown
// RULE25: on plus follow gives inrush limited start
//
// Local design decision: the plain strobed port.
module lsgpc_top (
    input  wire logic                           SYS_CLK,
    input  wire logic                           RSTN,
    input  wire logic [lsgpc_pkg::ADDR_W-1:0]   ADDR,
    input  wire logic [lsgpc_pkg::DATA_W-1:0]   WR_DATA,
    input  wire logic                           WR_STB,
    input  wire logic                           RD_STB,
    output logic      [lsgpc_pkg::DATA_W-1:0]   RD_DATA,
    input  wire logic                           PWM_IN,
    input  wire logic                           HOT_WARNING_EVENT,
    input  wire logic                           HOT_SECOND_THRESHOLD,
    input  wire logic [lsgpc_pkg::LAMP_N-1:0]   LAMP_OVERCURRENT,
    input  wire logic                           AUX_5V_OVERCURRENT,
    input  wire logic                           GLASS_SHORT,
    input  wire logic                           GLASS_OPEN_ABOVE,
    output logic      [lsgpc_pkg::LAMP_N-1:0]   LAMP_SWITCH_DRIVE,
    output logic                                AUX_5V_OUTPUT,
    output logic                                HB_HIGH_OFF,
    output logic                                HB_LOW_OFF,
    output logic                                H0_OFF,
    output logic                                POWER_STAGES_ENABLE,
    output logic                                GLASS_REGULATOR_DRIVE,
    output logic                                GLASS_SUPPLY_DRIVE,
    output logic                                GLASS_TEST_SOURCE,
    output logic      [lsgpc_pkg::CODE_W-1:0]   MIRROR_GLASS_CODE,
    output logic                                HOT_IRQ
);
    import lsgpc_pkg::*;

    lsgpc_state_t s_q;
    lsgpc_state_t s_d;

    logic [SYNC_W-1:0] pin;
    logic              pwm_rise;
    logic              wr_sys;
    logic              wr_hso;
    logic              wr_hsf;
    logic              wr_gls;
    logic              wr_glc;
    logic              wr_irf;
    logic              wr_irm;
    logic [LAMP_N-1:0] lamp_clr;
    logic              aux_clr;
    logic              short_clr;
    logic              open_clr;
    logic              hot_clr;
    logic              hs_kill;
    logic              all_kill;
    logic              hs_ok;
    logic              gl_ok;
    logic [LAMP_N-1:0] oc_ev;
    logic [DATA_W-1:0] rd_val;

    // ==========================================================
    // write decode and write-one-to-clear masks
    always_comb begin
        wr_sys    = WR_STB && (ADDR == OFS_SYS_CTRL);
        wr_hso    = WR_STB && (ADDR == OFS_HS_OUT_CTRL);
        wr_hsf    = WR_STB && (ADDR == OFS_HS_FAULTS);
        wr_gls    = WR_STB && (ADDR == OFS_GLASS_STAT);
        wr_glc    = WR_STB && (ADDR == OFS_GLASS_CODE);
        wr_irf    = WR_STB && (ADDR == OFS_IRQ_FLAGS);
        wr_irm    = WR_STB && (ADDR == OFS_IRQ_MASK);
        lamp_clr  = wr_hsf ? WR_DATA[POS_LAMP_OC +: LAMP_N] : '0;
        aux_clr   = wr_hsf && WR_DATA[POS_AUX_OC];
        short_clr = wr_gls && WR_DATA[POS_GL_SHORT];
        open_clr  = wr_gls && WR_DATA[POS_GL_OPEN];
        hot_clr   = wr_irf && WR_DATA[POS_HOT_FLAG];
    end

    // ==========================================================
    // read mux; unmapped offsets and reserved bits read zero
    always_comb begin
        rd_val = RST_BYTE;
        unique case (ADDR)
            OFS_SYS_CTRL: begin
                rd_val[POS_POWER_STAGES_ENABLE]      = s_q.power_stages_enable;
                rd_val[POS_HOT_SDDIS] = s_q.hot_sd_dis;
            end
            OFS_HS_OUT_CTRL: begin
                rd_val[POS_LAMP_ON +: LAMP_N]  = s_q.lamp_on;
                rd_val[POS_LAMP_PWM +: LAMP_N] = s_q.lamp_pwm;
                rd_val[POS_AUX_ON]             = s_q.aux_on;
            end
            OFS_HS_FAULTS: begin
                rd_val[POS_LAMP_OC +: LAMP_N] = s_q.lamp_oc;
                rd_val[POS_AUX_OC]            = s_q.aux_oc;
            end
            OFS_GLASS_STAT: begin
                rd_val[POS_GL_REG]   = s_q.gl_reg;
                rd_val[POS_GL_TEST]  = s_q.gl_test;
                rd_val[POS_GL_SUP]   = s_q.gl_sup;
                rd_val[POS_GL_SHORT] = s_q.gl_short;
                rd_val[POS_GL_OPEN]  = s_q.gl_open;
            end
            OFS_GLASS_CODE: begin
                rd_val[CODE_W-1:0] = s_q.gl_code;  // RULE21
            end
            OFS_IRQ_FLAGS: begin
                rd_val[POS_HOT_FLAG] = s_q.hot_flag;
            end
            OFS_IRQ_MASK: begin
                rd_val[POS_HOT_FLAG] = s_q.hot_mask;
            end
            default: begin
                rd_val = RST_BYTE;
            end
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        s_d = s_q;

        // pins pass two flops; only the second stage is read below
        s_d.sync1 = {GLASS_OPEN_ABOVE, GLASS_SHORT, AUX_5V_OVERCURRENT,
                     LAMP_OVERCURRENT, HOT_SECOND_THRESHOLD,
                     HOT_WARNING_EVENT, PWM_IN};
        s_d.sync2 = s_q.sync1;
        pin       = s_q.sync2;
        pwm_rise  = pin[SY_PWM] && !s_q.pwm_prev;
        s_d.pwm_prev = pin[SY_PWM];

        // software controlled bits
        if (wr_sys) begin
            s_d.power_stages_enable       = WR_DATA[POS_POWER_STAGES_ENABLE];          // RULE23
            s_d.hot_sd_dis = WR_DATA[POS_HOT_SDDIS];     // RULE24
        end
        if (wr_hso) begin
            s_d.lamp_on  = WR_DATA[POS_LAMP_ON +: LAMP_N];   // RULE12
            s_d.lamp_pwm = WR_DATA[POS_LAMP_PWM +: LAMP_N];  // RULE13
            s_d.aux_on   = WR_DATA[POS_AUX_ON];              // RULE9
        end
        if (wr_gls) begin
            s_d.gl_reg  = WR_DATA[POS_GL_REG];   // RULE22
            s_d.gl_sup  = WR_DATA[POS_GL_SUP];   // RULE22
            s_d.gl_test = WR_DATA[POS_GL_TEST];  // RULE17
        end
        if (wr_glc) begin
            s_d.gl_code = WR_DATA[CODE_W-1:0];   // RULE21
        end
        if (wr_irm) begin
            s_d.hot_mask = WR_DATA[POS_HOT_FLAG];
        end
        // clearing the open flag also drops both glass enables
        if (open_clr) begin
            s_d.gl_reg = 1'b0;  // RULE20
            s_d.gl_sup = 1'b0;  // RULE20
        end

        // hot flag: the live condition beats a clear, so no clear while hot
        s_d.hot_flag = pin[SY_HOT] || (s_q.hot_flag && !hot_clr);  // RULE1 RULE4
        hs_kill  = s_d.hot_flag && !s_q.hot_sd_dis;      // RULE3 RULE24
        all_kill = pin[SY_HOT2] && s_q.hot_sd_dis;       // RULE5
        hs_ok    = s_q.power_stages_enable && !hs_kill && !all_kill;    // RULE23

        // lamp switches; a fault is only seen while the switch conducts
        for (int i = 0; i < LAMP_N; i++) begin
            oc_ev[i] = pin[SY_LOC + i] && s_q.lamp_drv[i];
            s_d.lamp_oc[i] = oc_ev[i]
                             || (s_q.lamp_oc[i] && !lamp_clr[i]);  // RULE6 RULE14
            // cut holds the driver off until a pwm rising edge or a
            // written one; a set in the same cycle still wins
            s_d.lamp_cut[i] = oc_ev[i]
                              || (s_q.lamp_cut[i] && !pwm_rise
                                  && !lamp_clr[i]);  // RULE7 RULE14
            unique case ({s_q.lamp_pwm[i], s_q.lamp_on[i]})
                2'b00: s_d.lamp_drv[i] = 1'b0;
                2'b01: s_d.lamp_drv[i] = !s_d.lamp_oc[i];          // RULE6 RULE12
                2'b10: s_d.lamp_drv[i] = pin[SY_PWM]
                                         && !s_d.lamp_cut[i];      // RULE13 RULE7
                2'b11: s_d.lamp_drv[i] = !s_d.lamp_cut[i];         // RULE25
            endcase
            s_d.lamp_drv[i] = s_d.lamp_drv[i] && hs_ok;            // RULE3 RULE5
        end

        // aux output: limited in current, never switched off by a fault;
        // supply flags are not inputs here at all
        s_d.aux_oc  = pin[SY_AUXOC] || (s_q.aux_oc && !aux_clr);   // RULE11 RULE15
        s_d.aux_drv = s_q.power_stages_enable && s_q.aux_on && !all_kill;         // RULE9 RULE10

        // glass: a short latches and blocks drive until cleared
        s_d.gl_short = pin[SY_GSHORT]
                       || (s_q.gl_short && !short_clr);            // RULE18 RULE19
        s_d.gl_open  = (s_q.gl_test && pin[SY_GOPEN])
                       || (s_q.gl_open && !open_clr);              // RULE16 RULE20
        gl_ok = !s_q.gl_test && !s_d.gl_short && !all_kill;        // RULE17 RULE18
        s_d.gl_reg_drv  = s_q.gl_reg && gl_ok;                     // RULE22
        s_d.gl_sup_drv  = s_q.gl_sup && gl_ok;                     // RULE22
        s_d.gl_test_src = s_q.gl_test && !all_kill;                // RULE16
        s_d.gl_code_out = s_q.gl_code;

        // half-bridge and other stage kills
        s_d.hb_high_off = hs_kill || all_kill || !s_q.power_stages_enable;        // RULE3
        s_d.hb_low_off  = all_kill || !s_q.power_stages_enable;                   // RULE5
        s_d.h0_off      = all_kill;                                // RULE5
        s_d.stages_en   = s_q.power_stages_enable && !all_kill;                   // RULE23

        // interrupt request only through the mask
        s_d.irq = s_d.hot_flag && s_q.hot_mask;                    // RULE2

        // read data stand in the cycle after the strobe only
        s_d.rd_data = RD_STB ? rd_val : RST_BYTE;
    end

    // ==========================================================
    // state register
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs straight from flops
    assign RD_DATA               = s_q.rd_data;
    assign LAMP_SWITCH_DRIVE     = s_q.lamp_drv;
    assign AUX_5V_OUTPUT         = s_q.aux_drv;
    assign HB_HIGH_OFF           = s_q.hb_high_off;
    assign HB_LOW_OFF            = s_q.hb_low_off;
    assign H0_OFF                = s_q.h0_off;
    assign POWER_STAGES_ENABLE   = s_q.stages_en;
    assign GLASS_REGULATOR_DRIVE = s_q.gl_reg_drv;
    assign GLASS_SUPPLY_DRIVE    = s_q.gl_sup_drv;
    assign GLASS_TEST_SOURCE     = s_q.gl_test_src;
    assign MIRROR_GLASS_CODE     = s_q.gl_code_out;
    assign HOT_IRQ               = s_q.irq;

endmodule

// File: sim/lsgpc_sva.sv
// Purpose: port checks for the lamp, aux and glass controller
// Assumes: pins pass two sync flops and one output flop
// Notes:   bound to every lsgpc_top instance
module lsgpc_sva (
    input wire logic       SYS_CLK,
    input wire logic       RSTN,
    input wire logic [3:0] ADDR,
    input wire logic       WR_STB,
    input wire logic       RD_STB,
    input wire logic [7:0] RD_DATA,
    input wire logic       HOT_WARNING_EVENT,
    input wire logic       HOT_SECOND_THRESHOLD,
    input wire logic [2:0] LAMP_SWITCH_DRIVE,
    input wire logic       AUX_5V_OUTPUT,
    input wire logic       HB_HIGH_OFF,
    input wire logic       HB_LOW_OFF,
    input wire logic       H0_OFF,
    input wire logic       POWER_STAGES_ENABLE,
    input wire logic       GLASS_REGULATOR_DRIVE,
    input wire logic       GLASS_SUPPLY_DRIVE,
    input wire logic       GLASS_TEST_SOURCE,
    input wire logic       HOT_IRQ
);
    import lsgpc_pkg::*;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    // ==============================
    // register port
    rd_idle_a: assert property (!$past(RD_STB) |-> RD_DATA == 8'h00)
        else $error("read data outside its slot");
    unmapped_read_a: assert property ($past(RD_STB) && !($past(ADDR) inside
        {4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9}) |-> RD_DATA == 8'h00)
        else $error("unmapped read not zero");
    code_top_a: assert property (
        $past(RD_STB) && $past(ADDR) == OFS_GLASS_CODE |-> !RD_DATA[7:6])
        else $error("glass code upper bits set");
    // ==============================
    // power gating and kills
    aux_gate_a: assert property (
        AUX_5V_OUTPUT |-> POWER_STAGES_ENABLE && !H0_OFF)
        else $error("aux on without stages enable");
    lamp_gate_a: assert property (
        LAMP_SWITCH_DRIVE != 3'h0 |-> POWER_STAGES_ENABLE && !HB_HIGH_OFF)
        else $error("lamp on while high sides forced off");
    all_kill_a: assert property (H0_OFF |-> HB_HIGH_OFF && HB_LOW_OFF
        && !GLASS_REGULATOR_DRIVE && !GLASS_SUPPLY_DRIVE)
        else $error("stage left on during full kill");
    // a kill needs the pin three edges back, or a fresh write
    kill_cause_a: assert property (
        $rose(H0_OFF) |-> $past(HOT_SECOND_THRESHOLD, 3) || $past(WR_STB, 2))
        else $error("full kill without cause");
    glass_test_a: assert property (
        GLASS_TEST_SOURCE |-> !GLASS_REGULATOR_DRIVE && !GLASS_SUPPLY_DRIVE)
        else $error("glass driven during open-load test");
    // aux only limits current, so it drops only by write or kill
    aux_hold_a: assert property (
        $fell(AUX_5V_OUTPUT) |-> $past(WR_STB, 2) || H0_OFF)
        else $error("aux dropped without command");
    irq_cause_a: assert property ($rose(HOT_IRQ) |->
        $past(HOT_WARNING_EVENT, 3) || $past(HOT_WARNING_EVENT, 4)
        || $past(WR_STB, 2)) else $error("hot request without cause");
endmodule

bind lsgpc_top lsgpc_sva i_lsgpc_sva (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
    .ADDR(ADDR), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
    .HOT_WARNING_EVENT(HOT_WARNING_EVENT),
    .HOT_SECOND_THRESHOLD(HOT_SECOND_THRESHOLD),
    .LAMP_SWITCH_DRIVE(LAMP_SWITCH_DRIVE), .AUX_5V_OUTPUT(AUX_5V_OUTPUT),
    .HB_HIGH_OFF(HB_HIGH_OFF), .HB_LOW_OFF(HB_LOW_OFF), .H0_OFF(H0_OFF),
    .POWER_STAGES_ENABLE(POWER_STAGES_ENABLE),
    .GLASS_REGULATOR_DRIVE(GLASS_REGULATOR_DRIVE),
    .GLASS_SUPPLY_DRIVE(GLASS_SUPPLY_DRIVE),
    .GLASS_TEST_SOURCE(GLASS_TEST_SOURCE), .HOT_IRQ(HOT_IRQ));

// File: sim/lsgpc_loads.sv
// Purpose: lamp, aux and glass loads beside the controller
// Assumes: faults are commanded by the bench
// Notes:   slow=1 lags every answer by three clocks
module lsgpc_loads (
    input  wire logic       clk,
    input  wire logic       slow,
    input  wire logic [2:0] lamp_short,
    input  wire logic       aux_heavy,
    input  wire logic       glass_open,
    input  wire logic       glass_short,
    input  wire logic [2:0] lamp_drv,
    input  wire logic       aux_drv,
    input  wire logic       gl_drv,
    input  wire logic       gl_test,
    output logic      [2:0] lamp_oc,
    output logic            aux_oc,
    output logic            gl_above,
    output logic            gl_shorted
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] now_v;
    logic [5:0] d1_q;
    logic [5:0] d2_q;
    logic [5:0] d3_q;
    // ==============================
    // fault sensing
    // a fault only shows while its load is driven or under test
    assign now_v = {lamp_drv & lamp_short, aux_drv & aux_heavy,
                    gl_test & glass_open, gl_drv & glass_short};
    // lag line stands for a lazy comparator
    always @(posedge clk) begin
        d1_q <= now_v;
        d2_q <= d1_q;
        d3_q <= d2_q;
    end
    assign {lamp_oc, aux_oc, gl_above, gl_shorted} = slow ? d3_q : now_v;
endmodule

// File: sim/lsgpc_top_test.sv
// Purpose: self-checking bench of the lamp, aux and glass controller
// Assumes: pin effects show three edges after a pin change
// Notes:   register model m holds every expected read value
module lsgpc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import lsgpc_pkg::*;
    logic       clk = 0, rstn = 0, wr_s = 0, rd_s = 0, pwm = 0, hot = 0;
    logic       hot2 = 0, slow = 0, ahv = 0, gop = 0, gsh = 0;
    logic [3:0] addr = 0, a;
    logic [7:0] wdata = 0, rdata;
    logic [2:0] lsh = 0, loc, lamp;
    logic       aoc, gsc, gab, aux, hbh, hbl, h0, pse, greg, gsup, gtst, irq;
    logic [5:0] gcode;
    logic [3:0] ra[6] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'h9, 4'hf};
    int rwm[16] = '{8'h88, 8'hbf, 0, 0, 0, 8'he0, 8'h3f, 0, 0, 8'h01,
                    0, 0, 0, 0, 0, 0};
    int w1m[16] = '{0, 0, 0, 0, 8'h17, 8'h03, 0, 0, 8'h01, 0,
                    0, 0, 0, 0, 0, 0};
    int m[16];
    int mismatches = 0, n_checks = 0, seed = 38564;

    always #2 clk = ~clk;

    lsgpc_top i_lsgpc_top (.SYS_CLK(clk), .RSTN(rstn), .ADDR(addr),
        .WR_DATA(wdata), .WR_STB(wr_s), .RD_STB(rd_s), .RD_DATA(rdata),
        .PWM_IN(pwm), .HOT_WARNING_EVENT(hot), .HOT_SECOND_THRESHOLD(hot2),
        .LAMP_OVERCURRENT(loc), .AUX_5V_OVERCURRENT(aoc), .GLASS_SHORT(gsc),
        .GLASS_OPEN_ABOVE(gab), .LAMP_SWITCH_DRIVE(lamp), .AUX_5V_OUTPUT(aux),
        .HB_HIGH_OFF(hbh), .HB_LOW_OFF(hbl), .H0_OFF(h0),
        .POWER_STAGES_ENABLE(pse), .GLASS_REGULATOR_DRIVE(greg),
        .GLASS_SUPPLY_DRIVE(gsup), .GLASS_TEST_SOURCE(gtst),
        .MIRROR_GLASS_CODE(gcode), .HOT_IRQ(irq));
    lsgpc_loads i_lsgpc_loads (.clk(clk), .slow(slow), .lamp_short(lsh),
        .aux_heavy(ahv), .glass_open(gop), .glass_short(gsh),
        .lamp_drv(lamp), .aux_drv(aux), .gl_drv(greg | gsup), .gl_test(gtst),
        .lamp_oc(loc), .aux_oc(aoc), .gl_above(gab), .gl_shorted(gsc));

    // ==============================
    // shared tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    // model: plain bits copy, flag bits drop on a written one
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= ad;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
        m[ad] = (d & rwm[ad]) | (m[ad] & ~rwm[ad] & ~(d & w1m[ad]));
        // clearing the glass open flag also drops both glass enables
        if (ad == OFS_GLASS_STAT && d[POS_GL_OPEN])
            m[ad] = m[ad] & 8'h5f;
    endtask
    task automatic rd_chk(input logic [3:0] ad);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= ad;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk(rdata, m[ad][7:0]);
    endtask
    task automatic rst_chk();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        foreach (m[i])
            m[i] = 0;
        for (int i = 0; i < 16; i++)
            rd_chk(4'(i));
    endtask
    task automatic summarize();
        if (mismatches == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==============================
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        summarize();
    end

    // ==============================
    // main sequence
    initial begin
        rst_chk();
        for (int i = 0; i < 24; i++) begin
            a = ra[$unsigned($random(seed)) % 6];
            wr(a, 8'($random(seed)));
            rd_chk(a);
        end
        wr(OFS_SYS_CTRL, 8'h80);
        for (int md = 0; md < 4; md++)
            for (int p = 0; p < 2; p++) begin
                wr(OFS_HS_OUT_CTRL, {2'b00, {3{md[1]}}, {3{md[0]}}});
                @(posedge clk) pwm <= p[0];
                w(4);
                chk(lamp, (md[0] || (md[1] && p[0])) ? 8'h07 : 8'h00);
            end
        // hard short in plain on mode stays off until a one is written
        wr(OFS_HS_OUT_CTRL, 8'h07);
        @(posedge clk) lsh <= 3'h1;
        w(8);
        chk(lamp, 8'h06);
        m[4] = 8'h01;
        wr(OFS_HS_FAULTS, 8'h00);
        rd_chk(OFS_HS_FAULTS);
        @(posedge clk) lsh <= 3'h0;
        w(4);
        wr(OFS_HS_FAULTS, 8'h01);
        w(3);
        chk(lamp, 8'h07);
        // inrush: follow mode prompt, on+follow with a slow load
        for (int md = 2; md < 4; md++) begin
            @(posedge clk) slow <= md[0];
            wr(OFS_HS_OUT_CTRL, md[0] ? 8'h12 : 8'h10);
            @(posedge clk) lsh <= 3'h2;
            w(12);
            chk(lamp[1], 8'h00);
            m[4] = 8'h02;
            rd_chk(OFS_HS_FAULTS);
            @(posedge clk) pwm <= 1'b0;
            w(4);
            @(posedge clk) pwm <= 1'b1;
            w(4);
            chk(lamp[1], 8'h01);
            @(posedge clk) lsh <= 3'h0;
            w(8);
            wr(OFS_HS_FAULTS, 8'h02);
        end
        @(posedge clk) slow <= 1'b0;
        wr(OFS_HS_OUT_CTRL, 8'h87);
        @(posedge clk) ahv <= 1'b1;
        w(5);
        chk(aux, 8'h01);
        m[4] = 8'h10;
        rd_chk(OFS_HS_FAULTS);
        @(posedge clk) ahv <= 1'b0;
        w(4);
        wr(OFS_HS_FAULTS, 8'h10);
        rd_chk(OFS_HS_FAULTS);
        wr(OFS_SYS_CTRL, 8'h00);
        w(3);
        chk({pse, hbl, aux, lamp}, 8'h10);
        wr(OFS_SYS_CTRL, 8'h80);
        wr(OFS_HS_OUT_CTRL, 8'h07);
        // hot flag with auto shutdown, clear refused while hot
        for (int mk = 1; mk >= 0; mk--) begin
            wr(OFS_IRQ_MASK, 8'(mk));
            @(posedge clk) hot <= 1'b1;
            w(5);
            chk({irq, hbh, lamp}, {mk[0], 1'b1, 3'h0});
            wr(OFS_IRQ_FLAGS, 8'h01);
            m[8] = 8'h01;
            rd_chk(OFS_IRQ_FLAGS);
            @(posedge clk) hot <= 1'b0;
            w(4);
            wr(OFS_IRQ_FLAGS, 8'h01);
            w(3);
            chk({irq, lamp}, 8'h07);
        end
        // shutdown disabled: lamps ride the first threshold only
        wr(OFS_SYS_CTRL, 8'h88);
        @(posedge clk) hot <= 1'b1;
        w(5);
        chk(lamp, 8'h07);
        @(posedge clk) hot2 <= 1'b1;
        w(5);
        chk({h0, lamp}, 8'h08);
        @(posedge clk) hot2 <= 1'b0;
        w(5);
        chk({h0, lamp}, 8'h07);
        @(posedge clk) hot <= 1'b0;
        w(4);
        wr(OFS_IRQ_FLAGS, 8'h01);
        // glass code, drives, short, open-load test
        wr(OFS_GLASS_CODE, 8'hff);
        rd_chk(OFS_GLASS_CODE);
        wr(OFS_GLASS_STAT, 8'ha0);
        w(3);
        chk({greg, gsup, gcode}, 8'hff);
        @(posedge clk) gsh <= 1'b1;
        w(5);
        chk({greg, gsup}, 8'h00);
        m[5] = 8'ha2;
        rd_chk(OFS_GLASS_STAT);
        @(posedge clk) gsh <= 1'b0;
        w(4);
        wr(OFS_GLASS_STAT, 8'ha2);
        w(3);
        chk({greg, gsup}, 8'h03);
        wr(OFS_GLASS_STAT, 8'he0);
        @(posedge clk) gop <= 1'b1;
        w(5);
        chk({gtst, greg, gsup}, 8'h04);
        m[5] = 8'he1;
        rd_chk(OFS_GLASS_STAT);
        @(posedge clk) gop <= 1'b0;
        w(4);
        wr(OFS_GLASS_STAT, 8'he1);
        rd_chk(OFS_GLASS_STAT);
        rst_chk();
        summarize();
    end
endmodule
